/* bench/async_list_pointer_and_port_routing_test.sv */
// testbench for the async pointer and port routing register pair
// assumes the single-cycle register port; bench drives on falling edges
`timescale 1ns/1ps
`default_nettype none
module async_list_pointer_and_port_routing_test;
  import async_route_pkg::*;
  logic core_clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic [ADDR_W-1:0] reg_addr_i = 8'h00;
  logic [DATA_W-1:0] reg_wdata_i = 32'h00000000;
  logic [DATA_W-1:0] reg_rdata_o;
  logic [DATA_W-1:0] link;
  logic flag;
  logic [NUM_PORTS-1:0] owner;
  int mismatches = 0;
  int tests_run = 0;
  async_list_pointer_and_port_routing async_list_pointer_and_port_routing_inst (.core_clk_i(core_clk_i),
    .resetn_i(resetn_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o), .next_queue_head_link_o(link),
    .configure_flag_o(flag), .port_owner_hs_o(owner));
  initial begin
    forever #20 core_clk_i = ~core_clk_i;
  end
  // ****************************************
  // access and compare tasks
  // ****************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
      mismatches++;
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(negedge core_clk_i);
    reg_wr_i = 1'b1;
    reg_addr_i = a;
    reg_wdata_i = d;
    @(negedge core_clk_i);
    reg_wr_i = 1'b0;
  endtask
  // rdata stands one cycle only, so it is sampled at the falling edge
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(negedge core_clk_i);
    reg_rd_i = 1'b1;
    reg_addr_i = a;
    @(negedge core_clk_i);
    reg_rd_i = 1'b0;
    chk(reg_rdata_o, exp);
  endtask
  task automatic report_and_stop;
    $display("mismatches=%0d tests_run=%0d", mismatches, tests_run);
    if (mismatches == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    #(2000 * 40);
    mismatches++;
    report_and_stop();
  end
  // ****************************************
  // test sequence
  // ****************************************
  initial begin
    repeat (4) @(negedge core_clk_i);
    resetn_i = 1'b1;
    rd(8'h38, 32'h00000000);
    rd(8'h60, 32'h00000000);
    chk({31'h0, flag}, 32'h00000000);
    chk({30'h0, owner}, 32'h00000000);
    // low bits set on purpose: reads must still show them as zero
    wr(8'h38, 32'hFFFFFFFF);
    chk(link, 32'hFFFFFFE0);
    rd(8'h38, 32'hFFFFFFE0);
    wr(8'h38, 32'hA5A5A5A0);
    rd(8'h38, 32'hA5A5A5A0);
    wr(8'h60, 32'h00000001);
    chk({31'h0, flag}, 32'h00000001);
    chk({30'h0, owner}, 32'h00000000);
    @(negedge core_clk_i);
    chk({30'h0, owner}, 32'h00000003);
    rd(8'h60, 32'h00000001);
    wr(8'h3C, 32'h12345678);
    rd(8'h3C, 32'h00000000);
    chk(link, 32'hA5A5A5A0);
    wr(8'h60, 32'h00000000);
    chk({31'h0, flag}, 32'h00000000);
    @(negedge core_clk_i);
    chk({30'h0, owner}, 32'h00000000);
    wr(8'h60, 32'h00000001);
    chk({31'h0, flag}, 32'h00000001);
    resetn_i = 1'b0;
    repeat (2) @(negedge core_clk_i);
    resetn_i = 1'b1;
    chk({31'h0, flag}, 32'h00000000);
    chk({30'h0, owner}, 32'h00000000);
    rd(8'h38, 32'h00000000);
    report_and_stop();
  end
endmodule
`default_nettype wire

/* hw/async_list_pointer_and_port_routing.sv */
// async queue head pointer and port routing configure registers
// assumes a single-cycle register port on the host controller clock
// assumes one-cycle strobes; a read and a write may share a cycle
//
// Contract
// - pointer bits 31..5 read/write, reset zero
// - configure flag drives default port routing
// - flag zero routes ports to companion
// - flag one routes ports here
// - pointer bits 4..0 read zero
`timescale 1ns/1ps
`default_nettype none
module async_list_pointer_and_port_routing
  import async_route_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic resetn_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [ADDR_W-1:0] reg_addr_i,
  input wire logic [DATA_W-1:0] reg_wdata_i,
  output logic [DATA_W-1:0] reg_rdata_o,
  output logic [DATA_W-1:0] next_queue_head_link_o,
  output logic configure_flag_o,
  output logic [NUM_PORTS-1:0] port_owner_hs_o
);
  // ************************************************************
  // address decode
  // ************************************************************
  // exact byte-offset match; a near miss such as 0x3C hits nothing
  logic wr_ptr_hit;
  logic wr_flag_hit;
  logic rd_ptr_hit;
  logic rd_flag_hit;
  logic rd_miss;
  logic [NUM_PORTS-1:0] owner_w;

  // decoded once so the write logic and the checks agree on what a hit is; the read mux decodes reg_addr_i again
  assign wr_ptr_hit = reg_wr_i && (reg_addr_i == ASYNC_QH_PTR_OFF);
  assign wr_flag_hit = reg_wr_i && (reg_addr_i == PORT_ROUTE_CFG_OFF);
  assign rd_ptr_hit = reg_rd_i && (reg_addr_i == ASYNC_QH_PTR_OFF);
  assign rd_flag_hit = reg_rd_i && (reg_addr_i == PORT_ROUTE_CFG_OFF);
  // unmapped reads still answer, with zero, so software never stalls
  assign rd_miss = reg_rd_i && !rd_ptr_hit && !rd_flag_hit;

  // ************************************************************
  // state
  // ************************************************************
  typedef struct packed {
    logic [LINK_W-1:0] link;
    logic flag;
    logic [DATA_W-1:0] rdata;
  } reg_state_t;
  reg_state_t st_r;
  reg_state_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    if (wr_ptr_hit) begin
      // low five bits dropped; queue heads are 32-byte aligned
      st_nxt.link = reg_wdata_i[DATA_W-1:LINK_LSB];
    end
    if (wr_flag_hit) begin
      // bits 31..1 dropped; only the flag is kept
      st_nxt.flag = reg_wdata_i[FLAG_BIT];
    end
    // read data stands one cycle, zero otherwise
    st_nxt.rdata = READ_ZERO;
    if (reg_rd_i) begin
      unique case (reg_addr_i)
        ASYNC_QH_PTR_OFF: st_nxt.rdata = {st_r.link, LINK_LOW_ZERO};
        PORT_ROUTE_CFG_OFF: st_nxt.rdata = {{(DATA_W-1){1'b0}}, st_r.flag};
        // unmapped offsets read zero
        default: st_nxt.rdata = READ_ZERO;
      endcase
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      st_r.link <= LINK_RESET;
      st_r.flag <= FLAG_RESET;
      st_r.rdata <= READ_ZERO;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ************************************************************
  // port routing
  // ************************************************************
  // one select per root port; all share the flag, so routing is all or none
  // the extra register stage costs one cycle of lag after a flag write
  genvar gi;
  generate
    for (gi = 0; gi < NUM_PORTS; gi++) begin : g_port
      route_select route_select_inst (
        .core_clk_i(core_clk_i),
        .resetn_i(resetn_i),
        .configure_flag_i(st_r.flag),
        .owner_hs_o(owner_w[gi])
      );
    end
  endgenerate

  // ************************************************************
  // outputs
  // ************************************************************
  // owners come from the per-port registers, not from the flag itself
  assign reg_rdata_o = st_r.rdata;
  assign next_queue_head_link_o = {st_r.link, LINK_LOW_ZERO};
  assign configure_flag_o = st_r.flag;
  assign port_owner_hs_o = owner_w;

  // ************************************************************
  // register checks
  // ************************************************************
  ptr_write_a: assert property (
    @(posedge core_clk_i) disable iff (!resetn_i)
    wr_ptr_hit |=> next_queue_head_link_o[DATA_W-1:LINK_LSB] == $past(reg_wdata_i[DATA_W-1:LINK_LSB]))
    else $error("pointer not stored");

  ptr_hold_a: assert property (
    @(posedge core_clk_i) disable iff (!resetn_i)
    !wr_ptr_hit |=> $stable(next_queue_head_link_o))
    else $error("pointer changed without write");

  ptr_read_a: assert property (
    @(posedge core_clk_i) disable iff (!resetn_i)
    rd_ptr_hit |=> reg_rdata_o == $past(next_queue_head_link_o))
    else $error("pointer readback wrong");

  ptr_low_a: assert property (
    @(posedge core_clk_i) disable iff (!resetn_i)
    rd_ptr_hit |=> reg_rdata_o[LINK_LSB-1:0] == LINK_LOW_ZERO)
    else $error("pointer low bits not zero");

  miss_read_a: assert property (
    @(posedge core_clk_i) disable iff (!resetn_i)
    rd_miss |=> reg_rdata_o == READ_ZERO)
    else $error("unmapped read not zero");

  idle_read_a: assert property (
    @(posedge core_clk_i) disable iff (!resetn_i)
    !reg_rd_i |=> reg_rdata_o == READ_ZERO)
    else $error("read data outside a read");

  flag_write_a: assert property (
    @(posedge core_clk_i) disable iff (!resetn_i)
    wr_flag_hit |=> configure_flag_o == $past(reg_wdata_i[FLAG_BIT]))
    else $error("flag not stored");

  flag_hold_a: assert property (
    @(posedge core_clk_i) disable iff (!resetn_i)
    !wr_flag_hit |=> $stable(configure_flag_o))
    else $error("flag changed without write");

  flag_read_a: assert property (
    @(posedge core_clk_i) disable iff (!resetn_i)
    rd_flag_hit |=> reg_rdata_o == {{(DATA_W-1){1'b0}}, $past(configure_flag_o)})
    else $error("flag readback wrong");

  // ************************************************************
  // routing checks
  // ************************************************************
  // routing lags the flag by one register stage
  route_follow_a: assert property (
    @(posedge core_clk_i) disable iff (!resetn_i)
    ##1 port_owner_hs_o == {NUM_PORTS{$past(configure_flag_o)}})
    else $error("routing mismatch");

  route_same_a: assert property (
    @(posedge core_clk_i) disable iff (!resetn_i)
    port_owner_hs_o == '0 || &port_owner_hs_o)
    else $error("ports split between owners");

  route_comp_a: assert property (
    @(posedge core_clk_i) disable iff (!resetn_i)
    !configure_flag_o ##1 !configure_flag_o |-> port_owner_hs_o == '0)
    else $error("not companion");

  route_hs_a: assert property (
    @(posedge core_clk_i) disable iff (!resetn_i)
    configure_flag_o ##1 configure_flag_o |-> &port_owner_hs_o)
    else $error("not high speed");

  route_rise_a: assert property (
    @(posedge core_clk_i) disable iff (!resetn_i)
    $rose(configure_flag_o) |-> port_owner_hs_o == '0 ##1 &port_owner_hs_o)
    else $error("late hand-over to high speed");

  route_fall_a: assert property (
    @(posedge core_clk_i) disable iff (!resetn_i)
    $fell(configure_flag_o) |-> &port_owner_hs_o ##1 port_owner_hs_o == '0)
    else $error("late hand-back to companion");

  // ************************************************************
  // reset checks
  // ************************************************************
  // no disable here: these watch the reset itself
  ptr_reset_a: assert property (
    @(posedge core_clk_i)
    !resetn_i |=> next_queue_head_link_o == '0)
    else $error("pointer not cleared by reset");

  rdata_reset_a: assert property (
    @(posedge core_clk_i)
    !resetn_i |=> reg_rdata_o == READ_ZERO)
    else $error("read data not cleared by reset");

  flag_reset_a: assert property (
    @(posedge core_clk_i)
    !resetn_i |=> !configure_flag_o)
    else $error("flag not cleared by reset");

  owner_reset_a: assert property (
    @(posedge core_clk_i)
    !resetn_i |=> port_owner_hs_o == '0)
    else $error("ports not handed to companion by reset");
endmodule
`default_nettype wire

/* hw/async_route_pkg.sv */
// constants for the async list pointer and port routing register pair
// assumes a 32-bit memory-mapped register port with byte-address offsets
package async_route_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned NUM_PORTS = 2;
  localparam logic [ADDR_W-1:0] ASYNC_QH_PTR_OFF = 8'h38;
  localparam logic [ADDR_W-1:0] PORT_ROUTE_CFG_OFF = 8'h60;
  localparam int unsigned LINK_LSB = 5;
  localparam int unsigned LINK_W = 27;
  localparam int unsigned FLAG_BIT = 0;
  localparam logic [LINK_W-1:0] LINK_RESET = 27'h0000000;
  localparam logic FLAG_RESET = 1'b0;
  localparam logic [LINK_LSB-1:0] LINK_LOW_ZERO = 5'h00;
  localparam logic [DATA_W-1:0] READ_ZERO = 32'h00000000;
endpackage

/* hw/route_select.sv */
// one root port owner select, registered
// assumes the configure flag comes from a flip-flop in the same clock domain
`timescale 1ns/1ps
`default_nettype none
module route_select
  import async_route_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic resetn_i,
  input wire logic configure_flag_i,
  output logic owner_hs_o
);
  typedef struct packed {
    logic owner_hs;
  } sel_state_t;
  sel_state_t st_r;
  sel_state_t st_nxt;
  always_comb begin
    st_nxt = st_r;
    // flag alone picks the owner; 0 companion, 1 high speed
    st_nxt.owner_hs = configure_flag_i;
  end
  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
  assign owner_hs_o = st_r.owner_hs;
endmodule
`default_nettype wire
